// file: hdl/sfc_loader.sv
// serial flash configuration loader, control and link engine
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE_01: shift read command then start address out on mosi to the flash
// RULE_02: capture the bitstream serially from the flash data output
// RULE_03: drive active-low flash select, low while addressing the flash
// RULE_04: generate serial clock from link oscillator, rate from bitstream option
// RULE_05: drive the daisy-chain output throughout configuration
// RULE_06: pull init low at start while clearing configuration memory
// RULE_07: release init when clearing ends and sample mode inputs then
// RULE_08: slow flash must be covered by external logic holding init low
// RULE_09: drive init low when the bitstream check fails
// RULE_10: hold done low while configuring, release only after success
// RULE_11: program low for 500 ns or more restarts configuration on release
// RULE_12: configuration never starts while the program input is low
// RULE_13: program low puts all flash pins in high impedance
// RULE_14: after configuration drive flash select high to deselect
// RULE_15: after configuration drive the init pin high as a user pin
// RULE_16: mode inputs must read 0,0,1 when sampled for flash loading
// RULE_17: read command is issued once per attempt
// RULE_18: start at lowest serial clock rate, raise only if bitstream asks
// RULE_19: keep select low from read command until all bits are received
// RULE_20: msb first, flash and device both sample on rising serial clock
module sfc_loader #(
  parameter int unsigned CLEAR_CYC = sfc_pkg::CLEAR_US * sfc_pkg::CLK_MHZ,
  parameter int unsigned CFG_BITS  = 65536
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              osc_clk,
  input  wire logic              program_restart_n,
  input  wire logic [2:0]        mode_sel,
  input  wire logic              init_i,
  output logic                   init_o,
  output logic                   init_oe,
  input  wire logic              done_i,
  output logic                   done_o,
  output logic                   done_oe,
  input  wire logic              din,
  output sfc_pkg::sfc_pins_t     pins,
  output sfc_pkg::sfc_pins_t     pins_oe,
  output logic [31:0]            cfg_word,
  output logic                   cfg_word_valid,
  output logic                   cfg_done
);

  // clk domain
  sfc_pkg::sfc_ctl_st_t                  ctl_ff;
  logic [sfc_pkg::PROG_CNT_W-1:0]        prog_cnt_ff;
  logic [sfc_pkg::CLEAR_CNT_W-1:0]       clr_cnt_ff;
  logic                                  run_ff;
  logic                                  init_o_ff;
  logic                                  init_oe_ff;
  logic                                  done_oe_ff;
  logic                                  cfg_done_ff;
  sfc_pkg::sfc_pins_t                    pins_oe_ff;
  logic [31:0]                           word_out_ff;
  logic                                  word_vld_ff;
  logic                                  wtgl_d_ff;
  logic                                  prog_s;
  logic                                  init_s;
  logic [2:0]                            mode_s;
  logic                                  fin_s;
  logic                                  wtgl_s;
  logic                                  prog_long;
  logic                                  done_s;

  // link domain
  sfc_pkg::sfc_lnk_st_t                  lnk_ff;
  sfc_pkg::sfc_pins_t                    pins_ff;
  logic [sfc_pkg::HALF_W-1:0]            hcnt_ff;
  logic [sfc_pkg::RATE_W-1:0]            rate_ff;
  logic [sfc_pkg::CMD_BITS-1:0]          tx_ff;
  logic [sfc_pkg::BIT_CNT_W-1:0]         bit_cnt_ff;
  logic [31:0]                           rx_ff;
  logic [31:0]                           word_ff;
  logic                                  wtgl_ff;
  logic                                  first_ff;
  logic [15:0]                           crc_ff;
  logic [15:0]                           cmp_ff;
  logic                                  crc_ok_ff;
  logic                                  fin_ff;
  logic                                  run_s;
  logic [sfc_pkg::HALF_W-1:0]            half;
  logic                                  tick;
  logic                                  rise;
  logic                                  fall;
  logic [31:0]                           rx_nxt;
  logic [15:0]                           crc_nxt;
  logic [15:0]                           cmp_nxt;
  logic                                  in_crc_field;
  logic                                  last_bit;

  localparam logic [sfc_pkg::BIT_CNT_W-1:0] LAST_BIT =
    sfc_pkg::BIT_CNT_W'(CFG_BITS - 1);
  localparam logic [sfc_pkg::BIT_CNT_W-1:0] CRC_START =
    sfc_pkg::BIT_CNT_W'(CFG_BITS - sfc_pkg::CRC_W);
  localparam logic [sfc_pkg::CLEAR_CNT_W-1:0] CLEAR_LAST =
    sfc_pkg::CLEAR_CNT_W'(CLEAR_CYC - 1);
  localparam logic [sfc_pkg::PROG_CNT_W-1:0] PROG_LAST =
    sfc_pkg::PROG_CNT_W'(sfc_pkg::PROG_MIN_CYC - 1);

  // crossings into the clk domain
  sfc_sync #(.W(8)) u_sync_clk (
    .clk  (clk),
    .nrst (nrst),
    .d    ({program_restart_n, init_i, mode_sel, fin_ff, wtgl_ff, done_i}),
    .q    ({prog_s, init_s, mode_s, fin_s, wtgl_s, done_s})
  );

  // crossing into the link domain
  sfc_sync #(.W(1)) u_sync_osc (
    .clk  (osc_clk),
    .nrst (nrst),
    .d    (run_ff),
    .q    (run_s)
  );

  assign prog_long = (prog_cnt_ff == PROG_LAST);

  // program low pulse width measurement
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prog_cnt_ff <= '0;
    else if (prog_s)
      prog_cnt_ff <= '0;
    else if (!prog_long)
      prog_cnt_ff <= prog_cnt_ff + 1'b1; // RULE_11
  end

  // configuration control sequence
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_ff     <= sfc_pkg::C_CLEAR;
      clr_cnt_ff <= '0;
      run_ff     <= 1'b0;
    end
    else if (!prog_s && prog_long && ctl_ff != sfc_pkg::C_HOLD)
    begin
      ctl_ff <= sfc_pkg::C_HOLD; // RULE_11
      run_ff <= 1'b0;
    end
    else
    begin
      unique case (ctl_ff)
        sfc_pkg::C_HOLD:
        begin
          clr_cnt_ff <= '0;
          if (prog_s)
            ctl_ff <= sfc_pkg::C_CLEAR; // RULE_11
        end
        sfc_pkg::C_CLEAR:
        begin
          if (prog_s && !fin_s) // RULE_12
          begin
            if (clr_cnt_ff == CLEAR_LAST)
              ctl_ff <= sfc_pkg::C_INITW; // RULE_07
            else
              clr_cnt_ff <= clr_cnt_ff + 1'b1; // RULE_06
          end
        end
        sfc_pkg::C_INITW:
        begin
          if (init_s && prog_s) // RULE_08
          begin
            if (mode_s == sfc_pkg::MODE_SPI) // RULE_07 RULE_16
            begin
              ctl_ff <= sfc_pkg::C_LOAD;
              run_ff <= 1'b1; // RULE_17
            end
            else
              ctl_ff <= sfc_pkg::C_FAIL;
          end
        end
        sfc_pkg::C_LOAD:
        begin
          if (fin_s)
          begin
            run_ff <= 1'b0;
            ctl_ff <= crc_ok_ff ? sfc_pkg::C_CONF : sfc_pkg::C_FAIL; // RULE_09
          end
        end
        sfc_pkg::C_CONF:
          ctl_ff <= sfc_pkg::C_CONF;
        sfc_pkg::C_FAIL:
          ctl_ff <= sfc_pkg::C_FAIL;
      endcase
    end
  end

  // done open-drain drive, init open-drain until driven high in C_CONF
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_o_ff   <= 1'b0;
      init_oe_ff  <= 1'b1;
      done_oe_ff  <= 1'b1;
      cfg_done_ff <= 1'b0;
    end
    else
    begin
      init_o_ff   <= (ctl_ff == sfc_pkg::C_CONF); // RULE_15
      init_oe_ff  <= (ctl_ff == sfc_pkg::C_CLEAR) || (ctl_ff == sfc_pkg::C_HOLD)
                  || (ctl_ff == sfc_pkg::C_FAIL) || (ctl_ff == sfc_pkg::C_CONF); // RULE_06 RULE_09
      done_oe_ff  <= (ctl_ff != sfc_pkg::C_CONF); // RULE_10
      cfg_done_ff <= (ctl_ff == sfc_pkg::C_CONF) && done_s; // RULE_10
    end
  end

  // flash pin enables, released while program is low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pins_oe_ff <= '0;
    else if (!prog_s || ctl_ff == sfc_pkg::C_HOLD)
      pins_oe_ff <= '0; // RULE_13
    else
      pins_oe_ff <= '{flash_select_n: 1'b1, cfg_serial_clock: 1'b1, mosi: 1'b1,
                      dout: 1'b1}; // RULE_05 RULE_14
  end

  // received word hand-over, word held stable between toggles
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wtgl_d_ff   <= 1'b0;
      word_vld_ff <= 1'b0;
      word_out_ff <= '0;
    end
    else
    begin
      wtgl_d_ff   <= wtgl_s;
      word_vld_ff <= (wtgl_s != wtgl_d_ff);
      if (wtgl_s != wtgl_d_ff)
        word_out_ff <= word_ff; // RULE_02
    end
  end

  // serial clock divider
  always_comb
  begin
    unique case (rate_ff)
      2'h0: half = sfc_pkg::HALF_R0;
      2'h1: half = sfc_pkg::HALF_R1;
      2'h2: half = sfc_pkg::HALF_R2;
      2'h3: half = sfc_pkg::HALF_R3;
    endcase
  end

  assign tick = (lnk_ff == sfc_pkg::L_CMD || lnk_ff == sfc_pkg::L_DATA) && (hcnt_ff == '0);
  assign rise = tick && !pins_ff.cfg_serial_clock;
  assign fall = tick && pins_ff.cfg_serial_clock;

  always_ff @(posedge osc_clk or negedge nrst)
  begin
    if (!nrst)
      hcnt_ff <= '0;
    else if (lnk_ff == sfc_pkg::L_IDLE)
      hcnt_ff <= sfc_pkg::HALF_R0 - 1'b1; // RULE_18
    else if (tick)
      hcnt_ff <= half - 1'b1; // RULE_04
    else
      hcnt_ff <= hcnt_ff - 1'b1;
  end

  // bit capture and check sequence
  assign in_crc_field = (bit_cnt_ff >= CRC_START);
  assign last_bit     = (bit_cnt_ff == LAST_BIT);
  assign rx_nxt       = {rx_ff[30:0], din}; // RULE_20
  assign crc_nxt      = {crc_ff[14:0], 1'b0} ^ ((crc_ff[15] ^ din) ? sfc_pkg::CRC_POLY : '0);
  assign cmp_nxt      = {cmp_ff[14:0], din};

  // link engine
  always_ff @(posedge osc_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lnk_ff     <= sfc_pkg::L_IDLE;
      pins_ff    <= '{flash_select_n: 1'b1, cfg_serial_clock: 1'b0, mosi: 1'b0,
                      dout: 1'b0};
      rate_ff    <= sfc_pkg::RATE_SLOW;
      tx_ff      <= '0;
      bit_cnt_ff <= '0;
      rx_ff      <= '0;
      word_ff    <= '0;
      wtgl_ff    <= 1'b0;
      first_ff   <= 1'b1;
      crc_ff     <= sfc_pkg::CRC_INIT;
      cmp_ff     <= '0;
      crc_ok_ff  <= 1'b0;
      fin_ff     <= 1'b0;
    end
    else
    begin
      unique case (lnk_ff)
        sfc_pkg::L_IDLE:
        begin
          pins_ff.flash_select_n   <= 1'b1; // RULE_14
          pins_ff.cfg_serial_clock <= 1'b0;
          if (run_s)
          begin
            lnk_ff                 <= sfc_pkg::L_CMD;
            pins_ff.flash_select_n <= 1'b0; // RULE_03 RULE_19
            pins_ff.mosi           <= sfc_pkg::FLASH_READ_CMD[7]; // RULE_01
            tx_ff                  <= {sfc_pkg::FLASH_READ_CMD, sfc_pkg::FLASH_START};
            rate_ff                <= sfc_pkg::RATE_SLOW; // RULE_18
            bit_cnt_ff             <= '0;
            first_ff               <= 1'b1;
            crc_ff                 <= sfc_pkg::CRC_INIT;
            crc_ok_ff              <= 1'b0;
          end
        end
        sfc_pkg::L_CMD:
        begin
          if (!run_s)
            lnk_ff <= sfc_pkg::L_IDLE;
          else if (tick)
          begin
            pins_ff.cfg_serial_clock <= !pins_ff.cfg_serial_clock;
            if (rise && bit_cnt_ff[5:0] == sfc_pkg::CMD_LAST)
            begin
              lnk_ff     <= sfc_pkg::L_DATA;
              bit_cnt_ff <= '0;
            end
            else if (rise)
              bit_cnt_ff <= bit_cnt_ff + 1'b1;
            if (fall)
            begin
              tx_ff        <= {tx_ff[30:0], 1'b0};
              pins_ff.mosi <= tx_ff[30]; // RULE_01 RULE_20
            end
          end
        end
        sfc_pkg::L_DATA:
        begin
          if (!run_s)
            lnk_ff <= sfc_pkg::L_IDLE;
          else if (tick)
          begin
            pins_ff.cfg_serial_clock <= !pins_ff.cfg_serial_clock;
            if (rise)
            begin
              rx_ff        <= rx_nxt; // RULE_02
              pins_ff.dout <= din; // RULE_05
              bit_cnt_ff   <= bit_cnt_ff + 1'b1;
              if (in_crc_field)
                cmp_ff <= cmp_nxt;
              else
                crc_ff <= crc_nxt;
              if (bit_cnt_ff[4:0] == sfc_pkg::WORD_LAST)
              begin
                word_ff  <= rx_nxt;
                wtgl_ff  <= !wtgl_ff;
                first_ff <= 1'b0;
                if (first_ff)
                  rate_ff <= rx_nxt[sfc_pkg::RATE_LSB +: sfc_pkg::RATE_W]; // RULE_04 RULE_18
              end
              if (last_bit)
              begin
                lnk_ff                   <= sfc_pkg::L_FIN;
                pins_ff.flash_select_n   <= 1'b1; // RULE_19
                pins_ff.cfg_serial_clock <= 1'b0;
                crc_ok_ff                <= (cmp_nxt == crc_ff); // RULE_09
                fin_ff                   <= 1'b1;
              end
            end
          end
        end
        sfc_pkg::L_FIN:
        begin
          if (!run_s)
          begin
            fin_ff <= 1'b0;
            lnk_ff <= sfc_pkg::L_IDLE;
          end
        end
      endcase
    end
  end

  assign init_o         = init_o_ff;
  assign init_oe        = init_oe_ff;
  assign done_o         = 1'b0;
  assign done_oe        = done_oe_ff;
  assign pins           = pins_ff;
  assign pins_oe        = pins_oe_ff;
  assign cfg_word       = word_out_ff;
  assign cfg_word_valid = word_vld_ff;
  assign cfg_done       = cfg_done_ff;

endmodule
`default_nettype wire

// file: hdl/sfc_pkg.sv
// shared constants and types of the serial flash configuration loader
package sfc_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned PROG_MIN_NS  = 500;
  localparam int unsigned PROG_MIN_CYC = (PROG_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CLEAR_US     = 1000;
  localparam int unsigned PROG_CNT_W   = 8;
  localparam int unsigned CLEAR_CNT_W  = 24;

  // flash read sequence
  localparam logic [7:0]  FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] FLASH_START    = 24'h000000;
  localparam int unsigned CMD_BITS       = 32;
  localparam logic [5:0]  CMD_LAST       = 6'h1F;

  // bitstream layout
  localparam int unsigned WORD_W      = 32;
  localparam logic [4:0]  WORD_LAST   = 5'h1F;
  localparam int unsigned CRC_W       = 16;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam int unsigned BIT_CNT_W   = 32;
  localparam int unsigned RATE_LSB    = 0;
  localparam int unsigned RATE_W      = 2;

  // serial clock rates, half period in link clock cycles
  localparam logic [1:0]  RATE_SLOW   = 2'h0;
  localparam int unsigned HALF_W      = 4;
  localparam logic [3:0]  HALF_R0     = 4'h8;
  localparam logic [3:0]  HALF_R1     = 4'h4;
  localparam logic [3:0]  HALF_R2     = 4'h2;
  localparam logic [3:0]  HALF_R3     = 4'h1;

  // mode select pattern for serial flash loading
  localparam logic [2:0]  MODE_SPI    = 3'h1;

  typedef enum logic [2:0] {
    C_CLEAR,
    C_INITW,
    C_LOAD,
    C_CONF,
    C_FAIL,
    C_HOLD
  } sfc_ctl_st_t;

  typedef enum logic [1:0] {
    L_IDLE,
    L_CMD,
    L_DATA,
    L_FIN
  } sfc_lnk_st_t;

  // flash side pin levels and their output enables
  typedef struct packed {
    logic flash_select_n;
    logic cfg_serial_clock;
    logic mosi;
    logic dout;
  } sfc_pins_t;

endpackage

// file: hdl/sfc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module sfc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule
`default_nettype wire

// file: bench/sfc_loader_checker.sv
// concurrent checks on the ports of the configuration loader
`timescale 1ns/100ps
`default_nettype none
module sfc_loader_checker #(
  parameter int unsigned CLEAR_CYC = 20,
  parameter int unsigned CFG_BITS  = 64
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               osc_clk,
  input wire logic               program_restart_n,
  input wire logic               init_o,
  input wire logic               init_oe,
  input wire logic               done_i,
  input wire logic               done_o,
  input wire logic               done_oe,
  input wire logic               din,
  input wire sfc_pkg::sfc_pins_t pins,
  input wire sfc_pkg::sfc_pins_t pins_oe,
  input wire logic               cfg_word_valid,
  input wire logic               cfg_done
);
  logic [31:0] low_cnt_ff;

  // cycles with init driven low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      low_cnt_ff <= 32'h0;
    else if (init_oe && !init_o)
      low_cnt_ff <= low_cnt_ff + 32'h1;
    else
      low_cnt_ff <= 32'h0;
  end

  chk_prog_hiz: assert property (@(posedge clk) disable iff (!nrst)
    !program_restart_n [*4] |-> pins_oe == 4'h0) else $error("pins driven while program low");
  chk_init_clear: assert property (@(posedge clk) disable iff (!nrst)
    $fell(init_oe) |-> low_cnt_ff >= CLEAR_CYC - 1) else $error("init released early");
  chk_user_init: assert property (@(posedge clk) disable iff (!nrst)
    !done_oe && !$past(done_oe) |-> init_oe && init_o) else $error("init not high");
  chk_done_od: assert property (@(posedge clk) disable iff (!nrst)
    !done_o) else $error("done driven high");
  chk_done_flag: assert property (@(posedge clk) disable iff (!nrst)
    cfg_done |-> !done_oe && done_i) else $error("done flag without release");
  chk_word_pulse: assert property (@(posedge clk) disable iff (!nrst)
    cfg_word_valid |=> !cfg_word_valid) else $error("word valid too long");
  chk_cmd_first: assert property (@(posedge osc_clk) disable iff (!nrst)
    $fell(pins.flash_select_n) |-> !pins.mosi && !pins.cfg_serial_clock)
    else $error("bad first command bit");
  chk_slow_start: assert property (@(posedge osc_clk) disable iff (!nrst)
    $fell(pins.flash_select_n) |-> !pins.cfg_serial_clock [*8] ##1 pins.cfg_serial_clock)
    else $error("first half period not slow");
  chk_mosi_fall: assert property (@(posedge osc_clk) disable iff (!nrst)
    !pins.flash_select_n && !$past(pins.flash_select_n) && $changed(pins.mosi)
    |-> $fell(pins.cfg_serial_clock)) else $error("mosi moved off falling clock");
  chk_sclk_idle: assert property (@(posedge osc_clk) disable iff (!nrst)
    pins.flash_select_n |-> !pins.cfg_serial_clock) else $error("clock runs unselected");
  chk_dout_follow: assert property (@(posedge osc_clk) disable iff (!nrst)
    $changed(pins.dout) |-> pins.dout == $past(din)) else $error("dout not following din");
endmodule

bind sfc_loader sfc_loader_checker #(
  .CLEAR_CYC(CLEAR_CYC),
  .CFG_BITS(CFG_BITS)
) i_sfc_loader_checker (
  .clk(clk), .nrst(nrst), .osc_clk(osc_clk), .program_restart_n(program_restart_n),
  .init_o(init_o), .init_oe(init_oe), .done_i(done_i), .done_o(done_o),
  .done_oe(done_oe), .din(din), .pins(pins), .pins_oe(pins_oe),
  .cfg_word_valid(cfg_word_valid), .cfg_done(cfg_done)
);
`default_nettype wire

// file: bench/sfc_flash_model.sv
// behavioural serial flash answering one read from a loaded image
`timescale 1ns/100ps
`default_nettype none
module sfc_flash_model (
  input  wire logic        sel_n,
  input  wire logic        sclk,
  input  wire logic        si,
  input  wire logic [63:0] img,
  output var  logic        so,
  output var  logic [31:0] cmd,
  output var  logic [7:0]  nsel,
  output var  logic        fin,
  output var  logic [31:0] per0,
  output var  logic [31:0] per1
);
  int     bitn;
  longint t_last;

  initial
  begin
    so = 1'b0;
    cmd = 32'h0;
    nsel = 8'h0;
    fin = 1'b0;
    bitn = 0;
    t_last = 0;
    per0 = 32'h0;
    per1 = 32'h0;
  end
  always @(negedge sel_n)
  begin
    bitn = 0;
    fin = 1'b0;
    nsel = nsel + 8'h01;
  end
  // command sampled msb first on rising clock
  always @(posedge sclk)
    if (!sel_n)
    begin
      if (bitn < 32)
        cmd = {cmd[30:0], si};
      per1 = 32'($time - t_last);
      if (bitn == 1)
        per0 = per1;
      t_last = $time;
      bitn = bitn + 1;
    end
  // data launched on falling clock, msb first
  always @(negedge sclk)
    if (!sel_n)
      so = (bitn >= 32 && bitn < 96) ? img[95 - bitn] : ~so;
  // released output shows no stale value
  always @(posedge sel_n)
  begin
    so = ~so;
    fin = (bitn >= 95);
  end
endmodule
`default_nettype wire

// file: bench/sfc_loader_tb.sv
// self-checking bench of the serial flash configuration loader
`timescale 1ns/100ps
`default_nettype none
module sfc_loader_tb;
  localparam int unsigned CLR    = 20;
  localparam int unsigned BITS   = 64;
  localparam int unsigned OSC_NS = 160;
  logic               clk, nrst, osc_clk, program_restart_n, hold_init, din;
  logic               init_o, init_oe, done_o, done_oe, cfg_word_valid, cfg_done;
  logic               fin, init_w, done_w, f_sel, f_clk, f_si;
  logic [2:0]         mode_sel;
  logic [31:0]        cfg_word, seed, cmd, per0, per1;
  logic [63:0]        img;
  logic [7:0]         nsel, nsel_prev;
  sfc_pkg::sfc_pins_t pins, pins_oe;
  int                 errors, comparisons;
  logic [31:0]        exp_q [$];

  assign init_w = (init_oe && !init_o) || hold_init ? 1'b0 : 1'b1;
  assign done_w = done_oe ? 1'b0 : 1'b1;
  assign f_sel  = pins_oe.flash_select_n ? pins.flash_select_n : 1'b1;
  assign f_clk  = pins_oe.cfg_serial_clock ? pins.cfg_serial_clock : ~pins.cfg_serial_clock;
  assign f_si   = pins_oe.mosi ? pins.mosi : ~pins.mosi;

  sfc_loader #(.CLEAR_CYC(CLR), .CFG_BITS(BITS)) i_sfc_loader (
    .clk(clk), .nrst(nrst), .osc_clk(osc_clk), .program_restart_n(program_restart_n),
    .mode_sel(mode_sel), .init_i(init_w), .init_o(init_o), .init_oe(init_oe),
    .done_i(done_w), .done_o(done_o), .done_oe(done_oe), .din(din), .pins(pins),
    .pins_oe(pins_oe), .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid),
    .cfg_done(cfg_done));
  sfc_flash_model i_sfc_flash_model (
    .sel_n(f_sel), .sclk(f_clk), .si(f_si), .img(img), .so(din), .cmd(cmd),
    .nsel(nsel), .fin(fin), .per0(per0), .per1(per1));

  always #5 clk = ~clk;
  initial
  begin
    osc_clk = 1'b0;
    #2.3;
    forever #80 osc_clk = ~osc_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] crc48(input logic [47:0] d);
    logic [15:0] c;
    logic        fb;
    c = sfc_pkg::CRC_INIT;
    for (int i = 47; i >= 0; i--)
    begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? sfc_pkg::CRC_POLY : 16'h0);
    end
    return c;
  endfunction
  function automatic logic [31:0] per_ns(input logic [1:0] r);
    logic [3:0] h;
    case (r)
      2'h0: h = sfc_pkg::HALF_R0;
      2'h1: h = sfc_pkg::HALF_R1;
      2'h2: h = sfc_pkg::HALF_R2;
      default: h = sfc_pkg::HALF_R3;
    endcase
    return 32'(h) * 32'h2 * OSC_NS;
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results;
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic set_img(input logic [1:0] rate, input logic bad);
    seed = xs(seed);
    img[63:32] = {seed[31:2], rate};
    seed = xs(seed);
    img[31:16] = seed[15:0];
    img[15:0] = crc48(img[63:16]) ^ {15'h0, bad};
    exp_q = {img[63:32], img[31:0]};
  endtask
  task automatic pulse(input int n);
    program_restart_n = 1'b0;
    repeat (n) @(negedge clk);
    chk("pins_oe", 32'h0, pins_oe);
    program_restart_n = 1'b1;
  endtask
  task automatic finish_load(input logic [1:0] rate, input logic bad);
    int i;
    for (i = 0; i < 40000 && fin !== 1'b0; i++) @(negedge clk);
    chk("dout_oe", 32'h1, pins_oe.dout);
    for (i = 0; i < 40000 && fin !== 1'b1; i++) @(negedge clk);
    chk("fin", 32'h1, fin);
    repeat (40) @(negedge clk);
    chk("cmd", {sfc_pkg::FLASH_READ_CMD, sfc_pkg::FLASH_START}, cmd);
    chk("nsel", nsel_prev + 8'h01, nsel);
    chk("per0", per_ns(sfc_pkg::RATE_SLOW), per0);
    chk("per1", per_ns(rate), per1);
    chk("cfg_done", !bad, cfg_done);
    chk("init", !bad, init_w);
    chk("sel_n", 32'h1, pins.flash_select_n);
    if (!bad)
      chk("words", 32'h0, exp_q.size());
    exp_q.delete();
    nsel_prev = nsel;
  endtask

  // word scoreboard against the image
  always @(negedge clk)
    if (cfg_word_valid === 1'b1)
    begin
      chk("cfg_word", exp_q.size() ? exp_q[0] : ~cfg_word, cfg_word);
      if (exp_q.size())
        void'(exp_q.pop_front());
    end

  initial
  begin
    #1200000;
    errors = errors + 1;
    results();
  end

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    program_restart_n = 1'b1;
    mode_sel = sfc_pkg::MODE_SPI;
    hold_init = 1'b1;
    errors = 0;
    comparisons = 0;
    seed = 32'hE262C22D;
    nsel_prev = 8'h0;
    img = 64'h0;
    set_img(2'h0, 1'b0);
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (200) @(negedge clk);
    chk("nsel", 32'h0, nsel);
    hold_init = 1'b0;
    finish_load(2'h0, 1'b0);
    for (int r = 1; r < 5; r++)
    begin
      set_img((r == 4) ? 2'h3 : r[1:0], r == 4);
      pulse(60);
      finish_load((r == 4) ? 2'h3 : r[1:0], r == 4);
      if (r == 3)
      begin
        pulse(20);
        repeat (100) @(negedge clk);
        chk("cfg_done", 32'h1, cfg_done);
      end
    end
    mode_sel = 3'h2;
    pulse(60);
    repeat (400) @(negedge clk);
    chk("nsel", nsel_prev, nsel);
    chk("init", 32'h0, init_w);
    chk("done", 32'h0, done_w);
    results();
  end
endmodule
`default_nettype wire
